// ===== frtc_pkg.sv
// Purpose: Shared constants for the timer capture, mask and flag block
// Assumes: 16-bit register bus data, 4-bit register index
// Notes: Register indices below are word addresses on the plain port
package frtc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int CNT_W = 16;
	localparam int NUM_CAP = 4;

	// Register addresses
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h0;
	localparam logic [3:0] ADDR_FLAGS = 4'h1;
	localparam logic [3:0] ADDR_MASK_LENGTH = 4'h2;
	localparam logic [3:0] ADDR_CAPTURE_CTRL = 4'h3;
	localparam logic [3:0] ADDR_CAPTURE_A = 4'h4;
	localparam logic [3:0] ADDR_CAPTURE_B = 4'h5;
	localparam logic [3:0] ADDR_CAPTURE_C = 4'h6;
	localparam logic [3:0] ADDR_CAPTURE_D = 4'h7;

	// Reset values
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h01;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] MASK_LENGTH_RESET = 8'h00;
	localparam logic [7:0] CAPTURE_CTRL_RESET = 8'h00;
	localparam logic [15:0] CAPTURE_RESET = 16'h0000;

	// Field positions shared by the enable and flag registers; bit 0 is clear select in flags only, fixed one in enable
	localparam int BIT_CAP_A = 7;
	localparam int BIT_CAP_B = 6;
	localparam int BIT_CAP_C = 5;
	localparam int BIT_CAP_D = 4;
	localparam int BIT_CMP_A = 3;
	localparam int BIT_CMP_B = 2;
	localparam int BIT_OVERFLOW = 1;
	localparam int BIT_CLEAR_ON_MATCH_A = 0;
	localparam logic [7:0] FLAG_BITS = 8'hFE;
	localparam logic [7:0] IRQ_ENABLE_FIXED = 8'h01;

	// Capture control fields: edge selects a..d at 0..3
	localparam int BIT_EDGE_SELECT_A = 0;
	localparam int BIT_BUFFER_A_ENABLE = 4;
	localparam int BIT_BUFFER_B_ENABLE = 5;
	localparam int BIT_MASK_ENABLE = 6;
	localparam logic [7:0] CAPTURE_CTRL_BITS = 8'h7F;

	// Pin synchroniser depth
	localparam int SYNC_STAGES = 3;
endpackage

// ===== frtc_top.sv
// Purpose: Capture registers, capture-D mask interval, interrupt enables and flag/status register of a 16-bit timer
// Assumes: Counter, compare units and overflow detection live outside and arrive as same-clock strobes
// Notes: Capture pins are asynchronous and pass a three-stage synchroniser
module frtc_top (
	input wire logic sys_clk, // System clock, 50 MHz
	input wire logic rstn, // Synchronous reset, active low
	input wire logic standby, // Hardware standby, initialises like reset except the pin synchronisers
	input wire logic [3:0] addr, // Register address
	input wire logic [15:0] wr_data, // Write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	output logic [15:0] rd_data, // Read data, valid the cycle after rd_en
	input wire logic [3:0] capture_pin, // Capture inputs a..d, asynchronous
	input wire logic [15:0] running_counter, // Current counter value
	input wire logic cmp_a_match, // Compare A match strobe
	input wire logic cmp_b_match, // Compare B match strobe
	input wire logic counter_overflow, // Counter wrap strobe
	output logic counter_clear, // Request to clear counter
	output logic cap_a_irq, // Capture A interrupt request
	output logic cap_b_irq, // Capture B interrupt request
	output logic cap_c_irq, // Capture C interrupt request
	output logic cap_d_irq, // Capture D interrupt request
	output logic cmp_a_irq, // Compare A interrupt request
	output logic cmp_b_irq, // Compare B interrupt request
	output logic overflow_irq, // Overflow interrupt request
	output logic mask_active // Capture D mask interval in progress
);
	logic init;
	logic [7:0] timer_irq_enable, next_timer_irq_enable;
	logic [7:0] timer_flags_and_clear_select, next_timer_flags_and_clear_select;
	logic [7:0] clear_armed, next_clear_armed;
	logic [7:0] capture_d_mask_length, next_capture_d_mask_length;
	logic [7:0] capture_ctrl, next_capture_ctrl;
	logic [15:0] capture_reg_a, next_capture_reg_a;
	logic [15:0] capture_reg_b, next_capture_reg_b;
	logic [15:0] capture_reg_c, next_capture_reg_c;
	logic [15:0] capture_reg_d, next_capture_reg_d;
	logic [15:0] mask_end, next_mask_end;
	logic next_mask_active;
	logic [15:0] next_rd_data;
	logic [3:0] cap_event;
	logic cap_d_taken;
	logic [7:0] hw_set;
	logic buffer_a_enable, buffer_b_enable, capture_d_mask_enable, clear_on_match_a;

	assign init = !rstn || standby;
	assign buffer_a_enable = capture_ctrl[frtc_pkg::BIT_BUFFER_A_ENABLE];
	assign buffer_b_enable = capture_ctrl[frtc_pkg::BIT_BUFFER_B_ENABLE];
	assign capture_d_mask_enable = capture_ctrl[frtc_pkg::BIT_MASK_ENABLE];
	assign clear_on_match_a = timer_flags_and_clear_select[frtc_pkg::BIT_CLEAR_ON_MATCH_A];

	// Pin synchronisers and edge detection, one per capture input
	genvar gi;
	generate
		for (gi = 0; gi < frtc_pkg::NUM_CAP; gi++) begin : g_cap
			logic [2:0] sync, next_sync;
			logic level, next_level;
			logic edge_sel;
			always_comb begin
				next_sync = {sync[1:0], capture_pin[gi]};
				// Stage 0 feeds only stage 1; change counted once stages 1 and 2 agree
				next_level = (sync[1] == sync[2]) ? sync[2] : level;
			end
			always_ff @(posedge sys_clk) begin
				if (!rstn) begin
					sync <= 3'h0;
					level <= 1'b0;
				end else begin
					sync <= next_sync;
					level <= next_level;
				end
			end
			assign edge_sel = capture_ctrl[frtc_pkg::BIT_EDGE_SELECT_A + gi];
			// Rising when select is one, falling when zero
			assign cap_event[gi] = (next_level != level) && (next_level == edge_sel);
		end
	endgenerate

	// Masked capture D edges are dropped whole
	assign cap_d_taken = cap_event[3] && !mask_active;

	// Only hardware events set flags
	always_comb begin
		hw_set = 8'h00;
		hw_set[frtc_pkg::BIT_CAP_A] = cap_event[0];
		hw_set[frtc_pkg::BIT_CAP_B] = cap_event[1];
		hw_set[frtc_pkg::BIT_CAP_C] = cap_event[2];
		hw_set[frtc_pkg::BIT_CAP_D] = cap_d_taken;
		hw_set[frtc_pkg::BIT_CMP_A] = cmp_a_match;
		hw_set[frtc_pkg::BIT_CMP_B] = cmp_b_match;
		hw_set[frtc_pkg::BIT_OVERFLOW] = counter_overflow;
	end

	// Capture registers and mask interval
	always_comb begin
		next_capture_reg_a = capture_reg_a;
		next_capture_reg_b = capture_reg_b;
		next_capture_reg_c = capture_reg_c;
		next_capture_reg_d = capture_reg_d;
		next_mask_active = mask_active;
		next_mask_end = mask_end;
		if (cap_event[0]) begin
			next_capture_reg_a = running_counter;
			if (buffer_a_enable) begin
				next_capture_reg_c = capture_reg_a;
			end
		end
		// Buffered mode turns input C into a flag-only source
		if (cap_event[2] && !buffer_a_enable) begin
			next_capture_reg_c = running_counter;
		end
		if (cap_event[1]) begin
			next_capture_reg_b = running_counter;
			if (buffer_b_enable) begin
				next_capture_reg_d = capture_reg_b;
			end
		end
		if (cap_d_taken && !buffer_b_enable) begin
			next_capture_reg_d = running_counter;
		end
		if (mask_active && running_counter == mask_end) begin
			next_mask_active = 1'b0;
		end
		if (cap_d_taken && capture_d_mask_enable && capture_d_mask_length != 8'h00) begin
			next_mask_active = 1'b1;
			// Wraps mod 2^16 so intervals spanning the counter rollover still close
			next_mask_end = 16'(running_counter + {7'h00, capture_d_mask_length, 1'b0});
		end
	end

	always_ff @(posedge sys_clk) begin
		if (init) begin
			capture_reg_a <= frtc_pkg::CAPTURE_RESET;
			capture_reg_b <= frtc_pkg::CAPTURE_RESET;
			capture_reg_c <= frtc_pkg::CAPTURE_RESET;
			capture_reg_d <= frtc_pkg::CAPTURE_RESET;
			mask_active <= 1'b0;
			mask_end <= frtc_pkg::CAPTURE_RESET;
		end else begin
			capture_reg_a <= next_capture_reg_a;
			capture_reg_b <= next_capture_reg_b;
			capture_reg_c <= next_capture_reg_c;
			capture_reg_d <= next_capture_reg_d;
			mask_active <= next_mask_active;
			mask_end <= next_mask_end;
		end
	end

	// Software-visible registers
	always_comb begin
		next_timer_irq_enable = timer_irq_enable;
		next_capture_d_mask_length = capture_d_mask_length;
		next_capture_ctrl = capture_ctrl;
		next_timer_flags_and_clear_select = timer_flags_and_clear_select;
		next_clear_armed = clear_armed;
		if (wr_en) begin
			if (addr == frtc_pkg::ADDR_IRQ_ENABLE) begin
				next_timer_irq_enable = (wr_data[7:0] & ~frtc_pkg::IRQ_ENABLE_FIXED)
					| frtc_pkg::IRQ_ENABLE_FIXED;
			end else if (addr == frtc_pkg::ADDR_MASK_LENGTH) begin
				// Upper byte has no storage
				next_capture_d_mask_length = wr_data[7:0];
			end else if (addr == frtc_pkg::ADDR_CAPTURE_CTRL) begin
				next_capture_ctrl = wr_data[7:0] & frtc_pkg::CAPTURE_CTRL_BITS;
			end else if (addr == frtc_pkg::ADDR_FLAGS) begin
				// Zero clears a flag only if it was seen set; a one leaves it alone
				next_timer_flags_and_clear_select = timer_flags_and_clear_select
					& ~(clear_armed & ~wr_data[7:0] & frtc_pkg::FLAG_BITS);
				next_timer_flags_and_clear_select[frtc_pkg::BIT_CLEAR_ON_MATCH_A] =
					wr_data[frtc_pkg::BIT_CLEAR_ON_MATCH_A];
				next_clear_armed = 8'h00;
			end
		end
		if (rd_en && addr == frtc_pkg::ADDR_FLAGS) begin
			next_clear_armed = timer_flags_and_clear_select & frtc_pkg::FLAG_BITS;
		end
		// A set in the same cycle as a clear wins
		next_timer_flags_and_clear_select = next_timer_flags_and_clear_select | hw_set;
	end

	always_ff @(posedge sys_clk) begin
		if (init) begin
			timer_irq_enable <= frtc_pkg::IRQ_ENABLE_RESET;
			capture_d_mask_length <= frtc_pkg::MASK_LENGTH_RESET;
			capture_ctrl <= frtc_pkg::CAPTURE_CTRL_RESET;
			timer_flags_and_clear_select <= frtc_pkg::FLAGS_RESET;
			clear_armed <= 8'h00;
		end else begin
			timer_irq_enable <= next_timer_irq_enable;
			capture_d_mask_length <= next_capture_d_mask_length;
			capture_ctrl <= next_capture_ctrl;
			timer_flags_and_clear_select <= next_timer_flags_and_clear_select;
			clear_armed <= next_clear_armed;
		end
	end

	// Read path, registered so data appears the cycle after the strobe
	always_comb begin
		next_rd_data = 16'h0000;
		if (rd_en) begin
			if (addr == frtc_pkg::ADDR_IRQ_ENABLE) begin
				next_rd_data = {8'h00, timer_irq_enable | frtc_pkg::IRQ_ENABLE_FIXED};
			end else if (addr == frtc_pkg::ADDR_FLAGS) begin
				next_rd_data = {8'h00, timer_flags_and_clear_select};
			end else if (addr == frtc_pkg::ADDR_MASK_LENGTH) begin
				next_rd_data = {8'h00, capture_d_mask_length};
			end else if (addr == frtc_pkg::ADDR_CAPTURE_CTRL) begin
				next_rd_data = {8'h00, capture_ctrl};
			end else if (addr == frtc_pkg::ADDR_CAPTURE_A) begin
				next_rd_data = capture_reg_a;
			end else if (addr == frtc_pkg::ADDR_CAPTURE_B) begin
				next_rd_data = capture_reg_b;
			end else if (addr == frtc_pkg::ADDR_CAPTURE_C) begin
				next_rd_data = capture_reg_c;
			end else if (addr == frtc_pkg::ADDR_CAPTURE_D) begin
				next_rd_data = capture_reg_d;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (init) begin
			rd_data <= 16'h0000;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	// Interrupt requests are levels that follow flag and enable; the clear request follows the compare A strobe and clear select
	assign cap_a_irq = timer_flags_and_clear_select[frtc_pkg::BIT_CAP_A]
		&& timer_irq_enable[frtc_pkg::BIT_CAP_A];
	assign cap_b_irq = timer_flags_and_clear_select[frtc_pkg::BIT_CAP_B]
		&& timer_irq_enable[frtc_pkg::BIT_CAP_B];
	assign cap_c_irq = timer_flags_and_clear_select[frtc_pkg::BIT_CAP_C]
		&& timer_irq_enable[frtc_pkg::BIT_CAP_C];
	assign cap_d_irq = timer_flags_and_clear_select[frtc_pkg::BIT_CAP_D]
		&& timer_irq_enable[frtc_pkg::BIT_CAP_D];
	assign cmp_a_irq = timer_flags_and_clear_select[frtc_pkg::BIT_CMP_A]
		&& timer_irq_enable[frtc_pkg::BIT_CMP_A];
	assign cmp_b_irq = timer_flags_and_clear_select[frtc_pkg::BIT_CMP_B]
		&& timer_irq_enable[frtc_pkg::BIT_CMP_B];
	assign overflow_irq = timer_flags_and_clear_select[frtc_pkg::BIT_OVERFLOW]
		&& timer_irq_enable[frtc_pkg::BIT_OVERFLOW];
	assign counter_clear = cmp_a_match && clear_on_match_a;
endmodule

// ===== frtc_checker.sv
// Purpose: Port-level checks of the timer capture, mask and flag block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Sees only top-module ports, attached by bind
module frtc_checker (
	input wire logic sys_clk, // Clock
	input wire logic rstn, // Reset, active low
	input wire logic standby, // Standby
	input wire logic [3:0] addr, // Address
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	input wire logic [15:0] rd_data, // Read data
	input wire logic cmp_a_match, // Compare A strobe
	input wire logic counter_overflow, // Overflow strobe
	input wire logic counter_clear, // Counter clear request
	input wire logic cmp_a_irq, // Compare A request
	input wire logic overflow_irq, // Overflow request
	input wire logic cap_d_irq, // Capture D request
	input wire logic mask_active // Mask interval
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	AST_MASK_HI: assert property ($past(rd_en) && $past(addr) == frtc_pkg::ADDR_MASK_LENGTH |-> rd_data[15:8] == 8'h00)
		else $error("mask length upper byte not zero");
	AST_IE_BIT0: assert property ($past(rd_en) && !$past(standby) && $past(addr) == frtc_pkg::ADDR_IRQ_ENABLE
		|-> rd_data[0] == 1'b1) else $error("enable bit 0 not one");
	AST_CLEAR_CAUSE: assert property (counter_clear |-> cmp_a_match) else $error("clear without match");
	AST_OVF_RISE: assert property ($rose(overflow_irq) |-> $past(counter_overflow) || $past(wr_en))
		else $error("overflow request without cause");
	AST_CMPA_RISE: assert property ($rose(cmp_a_irq) |-> $past(cmp_a_match) || $past(wr_en))
		else $error("compare request without cause");
	AST_OVF_FALL: assert property ($fell(overflow_irq) |-> $past(wr_en) || $past(standby))
		else $error("overflow request dropped without write");
	AST_RESET_IRQ: assert property ($past(rstn) == 1'b0 |-> !overflow_irq && !cmp_a_irq && !cap_d_irq)
		else $error("request high after reset");
	AST_STANDBY_INIT: assert property (standby |=> !mask_active && !overflow_irq)
		else $error("standby did not initialise");
	AST_MASK_DROP: assert property (mask_active && $past(mask_active) |-> !$rose(cap_d_irq) || $past(wr_en))
		else $error("capture D accepted during mask");
endmodule
bind frtc_top frtc_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .standby(standby), .addr(addr), .wr_en(wr_en),
	.rd_en(rd_en), .rd_data(rd_data), .cmp_a_match(cmp_a_match), .counter_overflow(counter_overflow),
	.counter_clear(counter_clear), .cmp_a_irq(cmp_a_irq), .overflow_irq(overflow_irq), .cap_d_irq(cap_d_irq),
	.mask_active(mask_active));

// ===== tb_top.sv
// Purpose: Self-checking bench for the timer capture, mask and flag block
// Assumes: Bench holds the counter value steady around capture events
// Notes: Pin events land about four cycles late, so pin steps wait six
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, rstn, standby, wr_en, rd_en, cmp_a_match, cmp_b_match, counter_overflow, counter_clear;
	logic cap_a_irq, cap_b_irq, cap_c_irq, cap_d_irq, cmp_a_irq, cmp_b_irq, overflow_irq, mask_active;
	logic [3:0] addr, capture_pin;
	logic [15:0] wr_data, running_counter, rd_data, v, r1, r2, len;
	logic [31:0] seed = 32'hF3C6C5E6;
	int n_errors = 0;
	int check_count = 0;
	frtc_top DUT (.sys_clk(sys_clk), .rstn(rstn), .standby(standby), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .capture_pin(capture_pin), .running_counter(running_counter),
		.cmp_a_match(cmp_a_match), .cmp_b_match(cmp_b_match), .counter_overflow(counter_overflow),
		.counter_clear(counter_clear), .cap_a_irq(cap_a_irq), .cap_b_irq(cap_b_irq), .cap_c_irq(cap_c_irq),
		.cap_d_irq(cap_d_irq), .cmp_a_irq(cmp_a_irq), .cmp_b_irq(cmp_b_irq), .overflow_irq(overflow_irq),
		.mask_active(mask_active));
	task automatic rnd(output logic [15:0] r);
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		r = seed[15:0];
	endtask
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [3:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 chk(n, rd_data, exp);
	endtask
	task automatic pin(input int i, input logic lvl);
		@(posedge sys_clk);
		capture_pin[i] <= lvl;
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	task automatic strobes(input logic clr_exp);
		@(posedge sys_clk);
		cmp_a_match <= 1'b1;
		cmp_b_match <= 1'b1;
		counter_overflow <= 1'b1;
		#1 chk("counter_clear", 16'(counter_clear), 16'(clr_exp));
		@(posedge sys_clk);
		{cmp_a_match, cmp_b_match, counter_overflow} <= 3'h0;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Whole run needs roughly 240 cycles
	initial begin
		#400000;
		n_errors++;
		complete_run();
	end
	initial begin
		{rstn, standby, wr_en, rd_en, cmp_a_match, cmp_b_match, counter_overflow} = 7'h00;
		{addr, capture_pin, wr_data, running_counter} = 40'h0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		rdc("irq_enable", frtc_pkg::ADDR_IRQ_ENABLE, 16'h0001);
		rdc("flags", frtc_pkg::ADDR_FLAGS, 16'h0000);
		rdc("mask_length", frtc_pkg::ADDR_MASK_LENGTH, 16'h0000);
		for (int a = 8; a < 16; a++) rdc("unmapped", 4'(a), 16'h0000);
		repeat (4) begin
			rnd(v);
			wr(frtc_pkg::ADDR_IRQ_ENABLE, v);
			rdc("irq_enable", frtc_pkg::ADDR_IRQ_ENABLE, {8'h00, v[7:1], 1'b1});
			rnd(v);
			wr(frtc_pkg::ADDR_MASK_LENGTH, v);
			rdc("mask_length", frtc_pkg::ADDR_MASK_LENGTH, {8'h00, v[7:0]});
		end
		wr(frtc_pkg::ADDR_FLAGS, 16'h00FF);
		rdc("flags", frtc_pkg::ADDR_FLAGS, 16'h0001);
		wr(frtc_pkg::ADDR_IRQ_ENABLE, 16'h00FE);
		strobes(1'b1);
		#1 chk("cmp_irqs", 16'({cmp_a_irq, cmp_b_irq, overflow_irq}), 16'h0007);
		wr(frtc_pkg::ADDR_FLAGS, 16'h0001);
		rdc("flags", frtc_pkg::ADDR_FLAGS, 16'h000F);
		wr(frtc_pkg::ADDR_FLAGS, 16'h0000);
		rdc("flags", frtc_pkg::ADDR_FLAGS, 16'h0000);
		strobes(1'b0);
		wr(frtc_pkg::ADDR_IRQ_ENABLE, 16'h0000);
		#1 chk("cmp_irqs", 16'({cmp_a_irq, cmp_b_irq, overflow_irq}), 16'h0000);
		wr(frtc_pkg::ADDR_IRQ_ENABLE, 16'h00F0);
		wr(frtc_pkg::ADDR_CAPTURE_CTRL, 16'h001F);
		rnd(r1);
		running_counter <= r1;
		pin(0, 1'b1);
		rnd(r2);
		running_counter <= r2;
		pin(0, 1'b0);
		rdc("capture_a", frtc_pkg::ADDR_CAPTURE_A, r1);
		pin(0, 1'b1);
		rdc("capture_a", frtc_pkg::ADDR_CAPTURE_A, r2);
		pin(2, 1'b1);
		rdc("capture_c", frtc_pkg::ADDR_CAPTURE_C, r1);
		chk("cap_irqs", 16'({cap_a_irq, cap_c_irq}), 16'h0003);
		wr(frtc_pkg::ADDR_CAPTURE_CTRL, 16'h002F);
		pin(1, 1'b1);
		pin(1, 1'b0);
		running_counter <= r1;
		pin(1, 1'b1);
		rdc("capture_b", frtc_pkg::ADDR_CAPTURE_B, r1);
		rdc("capture_d", frtc_pkg::ADDR_CAPTURE_D, r2);
		chk("cap_b_irq", 16'(cap_b_irq), 16'h0001);
		rdc("flags", frtc_pkg::ADDR_FLAGS, 16'h00EE);
		wr(frtc_pkg::ADDR_FLAGS, 16'h0000);
		wr(frtc_pkg::ADDR_CAPTURE_CTRL, 16'h0048);
		rnd(len);
		len = {8'h00, len[7:1], 1'b1};
		wr(frtc_pkg::ADDR_MASK_LENGTH, len);
		// Base near the top so the end value usually wraps
		r1 = 16'hFF80 | r2;
		running_counter <= r1;
		pin(3, 1'b1);
		rdc("capture_d", frtc_pkg::ADDR_CAPTURE_D, r1);
		chk("mask_active", 16'(mask_active), 16'h0001);
		rdc("flags", frtc_pkg::ADDR_FLAGS, 16'h0010);
		wr(frtc_pkg::ADDR_FLAGS, 16'h0000);
		running_counter <= r1 + 16'h0001;
		pin(3, 1'b0);
		pin(3, 1'b1);
		rdc("capture_d", frtc_pkg::ADDR_CAPTURE_D, r1);
		chk("cap_d_irq", 16'(cap_d_irq), 16'h0000);
		running_counter <= r1 + (len << 1);
		repeat (3) @(posedge sys_clk);
		#1 chk("mask_active", 16'(mask_active), 16'h0000);
		wr(frtc_pkg::ADDR_MASK_LENGTH, 16'h0000);
		pin(3, 1'b0);
		running_counter <= r2;
		pin(3, 1'b1);
		rdc("capture_d", frtc_pkg::ADDR_CAPTURE_D, r2);
		chk("mask_active", 16'(mask_active), 16'h0000);
		// Falling-edge select on input A, pin A is high here
		wr(frtc_pkg::ADDR_CAPTURE_CTRL, 16'h0000);
		running_counter <= len;
		pin(0, 1'b0);
		rdc("capture_a_fall", frtc_pkg::ADDR_CAPTURE_A, len);
		wr(frtc_pkg::ADDR_MASK_LENGTH, 16'h00A5);
		@(posedge sys_clk);
		standby <= 1'b1;
		@(posedge sys_clk);
		standby <= 1'b0;
		rdc("irq_enable", frtc_pkg::ADDR_IRQ_ENABLE, 16'h0001);
		rdc("flags", frtc_pkg::ADDR_FLAGS, 16'h0000);
		rdc("mask_length", frtc_pkg::ADDR_MASK_LENGTH, 16'h0000);
		complete_run();
	end
endmodule
